/* dv/rmul_host.sv */
// host datapath model driving operand pins and load strobes
`timescale 1ns/100ps
module rmul_host
	import rmul_pkg::*;
(
	// clock
	input  wire logic            pclk,
	// operand pins
	output logic      [OPW-1:0]  x_data,
	output wire logic [OPW-1:0]  y_in,
	input  wire logic [OPW-1:0]  y_out,
	input  wire logic            y_oe,
	// strobes: 0..3 pin clocks x,y,upper,lower; 4..6 enables x,y,product
	output logic      [6:0]      strobe
);
	logic [OPW-1:0] y_drv;

	assign y_in = y_oe ? y_out : y_drv;

	initial begin
		x_data = 16'h0000;
		y_drv  = 16'h0000;
		strobe = 7'h00;
	end

	// data held well past the strobe so the two-flop sampling sees it settled
	task automatic load(input logic [6:0] m, input logic [OPW-1:0] xv, input logic [OPW-1:0] yv);
		x_data <= xv;
		y_drv  <= yv;
		repeat (2) @(posedge pclk);
		strobe <= m;
		@(posedge pclk);
		strobe <= 7'h00;
		repeat (4) @(posedge pclk);
		// released pins no longer carry the operand
		x_data <= ~xv;
		y_drv  <= ~yv;
		@(posedge pclk);
	endtask
endmodule

/* dv/tb_registered_16x16_multiplier.sv */
// self-checking bench for the registered multiplier
`timescale 1ns/100ps
module tb_registered_16x16_multiplier
	import rmul_pkg::*;
;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, y_oe, product_oe, er, ce;
	logic [AW-1:0]  paddr;
	logic [DW-1:0]  pwdata, prdata, rd, c, pv;
	logic [OPW-1:0] x_data, y_in, y_out, product_out, xv, yv;
	logic [6:0]     strobe;
	logic [3:0]     m;
	int             error_cnt, cmp_count, cyc;
	// xs ys fa rnd, x, y, expected {upper, lower}
	logic [67:0]    rows [7] = '{
		{4'b0010, 16'hFFFF, 16'hFFFF, 32'hFFFE0001},
		{4'b1110, 16'h8000, 16'h8000, 32'h40000000},
		{4'b1010, 16'hFFFF, 16'h0003, 32'hFFFFFFFD},
		{4'b0110, 16'h0005, 16'hFFFE, 32'hFFFFFFF6},
		{4'b1100, 16'h4000, 16'hC000, 32'hE0008000},
		{4'b1101, 16'h7FFF, 16'h1234, 32'h12342DCC},
		{4'b0011, 16'h00FF, 16'h0081, 32'h0001007F}};

	rmul_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .x_data(x_data), .y_in(y_in), .y_out(y_out), .y_oe(y_oe),
		.x_operand_clock(strobe[0]), .y_operand_clock(strobe[1]), .upper_product_clock(strobe[2]),
		.lower_product_clock(strobe[3]), .x_load_enable(strobe[4]), .y_load_enable(strobe[5]),
		.product_load_enable(strobe[6]), .product_out(product_out), .product_oe(product_oe));
	rmul_host host (.pclk(pclk), .x_data(x_data), .y_in(y_in), .y_out(y_out), .y_oe(y_oe), .strobe(strobe));

	always #2 pclk = ~pclk;

	task automatic tally_and_finish();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the hang guard ends a stalled access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// hang guard, more than seven thousand cycles above the expected run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		ce = 1'b1;
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk_b(product_oe, 1'b0);
		chk_b(y_oe, 1'b0);
		apb(1'b0, REG_CTRL, 32'h0);
		chk_w(rd, 32'h00000188);
		for (int i = 0; i < 7; i++) begin
			{m, xv, yv, pv} = rows[i];
			c = {23'h0, 1'b1, 1'b0, 1'b0, m[0], 1'b0, m[1], m[2], m[3], 1'b0};
			apb(1'b1, REG_CTRL, c);
			host.load(7'h03, xv, yv);
			host.load(7'h0C, xv, yv);
			chk_w(32'(product_out), {16'h0, pv[31:16]});
			chk_b(product_oe, 1'b1);
			apb(1'b0, REG_STATUS, 32'h0);
			chk_w(rd, {29'h0, m[0], m[2], m[3]});
			apb(1'b1, REG_CTRL, c ^ 32'h00000140);
			repeat (2) @(posedge pclk);
			chk_w(32'(product_out), {16'h0, pv[15:0]});
			chk_b(y_oe, 1'b1);
			chk_w(32'(y_in), {16'h0, pv[15:0]});
			apb(1'b0, REG_PRODUCT, 32'h0);
			chk_w(rd, pv);
		end
		// upper half alone, then lower half
		apb(1'b1, REG_CTRL, 32'h00000108);
		host.load(7'h03, 16'h0002, 16'h0003);
		host.load(7'h04, 16'h0002, 16'h0003);
		chk_w(32'(product_out), 32'h0);
		apb(1'b0, REG_PRODUCT, 32'h0);
		chk_w(rd, 32'h0000007F);
		host.load(7'h08, 16'h0002, 16'h0003);
		apb(1'b0, REG_PRODUCT, 32'h0);
		chk_w(rd, 32'h00000006);
		// single clock: y enable must leave x untouched
		apb(1'b1, REG_CTRL, 32'h00000109);
		host.load(7'h20, 16'h0010, 16'h0007);
		apb(1'b0, REG_OPERAND, 32'h0);
		chk_w(rd, 32'h00070002);
		host.load(7'h40, 16'h0010, 16'h0007);
		apb(1'b0, REG_PRODUCT, 32'h0);
		chk_w(rd, 32'h0000000E);
		// transparent product, round taken with y load alone
		apb(1'b1, REG_CTRL, 32'h00000138);
		host.load(7'h02, 16'h0010, 16'h0100);
		apb(1'b0, REG_PRODUCT, 32'h0);
		chk_w(rd, 32'h00008200);
		apb(1'b0, REG_STATUS, 32'h0);
		chk_w(rd, 32'h00000004);
		apb(1'b1, REG_PRODUCT, 32'hFFFFFFFF);
		chk_b(er, 1'b0);
		apb(1'b0, REG_PRODUCT, 32'h0);
		chk_w(rd, 32'h00008200);
		// frozen clock enable: a pin clock pulse must go unseen
		ce <= 1'b0;
		host.load(7'h03, 16'h1111, 16'h2222);
		ce <= 1'b1;
		apb(1'b0, REG_OPERAND, 32'h0);
		chk_w(rd, 32'h01000002);
		apb(1'b0, 8'h10, 32'h0);
		chk_b(er, 1'b1);
		chk_w(rd, 32'h0);
		// reset in mid-run returns enables and control to idle
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk_b(product_oe, 1'b0);
		chk_b(y_oe, 1'b0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, REG_CTRL, 32'h0);
		chk_w(rd, 32'h00000188);
		apb(1'b0, REG_PRODUCT, 32'h0);
		chk_w(rd, 32'h0);
		tally_and_finish();
	end
endmodule

/* rtl/rmul_core.sv */
// combinational 16x16 array with sign modes, round and format adjust
`timescale 1ns/100ps
module rmul_core
	import rmul_pkg::*;
(
	// operands in, formatted product out
	rmul_mul_if.core m
);
	wire signed [OPW:0]   x_ext;
	wire signed [OPW:0]   y_ext;
	wire signed [PW+1:0]  full;
	wire        [PW+1:0]  round_add;
	wire        [PW+1:0]  rounded;

	assign x_ext = {m.xs & m.x[OPW-1], m.x};
	assign y_ext = {m.ys & m.y[OPW-1], m.y};
	assign full = (PW+2)'(x_ext) * (PW+2)'(y_ext);
	assign round_add = !m.rnd ? '0 :
		(m.fa ? ((PW+2)'(1) << RND_POS_FULL) : ((PW+2)'(1) << RND_POS_SHIFT));
	assign rounded = full + round_add;
	assign m.hi = m.fa ? rounded[PW-1:OPW] : rounded[PW-2:OPW-1];
	assign m.lo = m.fa ? rounded[OPW-1:0] : {rounded[PW-1], rounded[OPW-2:0]};
endmodule

/* rtl/rmul_mul_if.sv */
// operand and product bundle between the register file and the array
`timescale 1ns/100ps
interface rmul_mul_if;
	logic [15:0] x;
	logic [15:0] y;
	logic        xs;
	logic        ys;
	logic        fa;
	logic        rnd;
	logic [15:0] hi;
	logic [15:0] lo;
	modport src  (output x, y, xs, ys, fa, rnd, input hi, lo);
	modport core (input x, y, xs, ys, fa, rnd, output hi, lo);
endinterface

/* rtl/rmul_pkg.sv */
// constants and types shared by the registered multiplier
package rmul_pkg;
	localparam int OPW = 16;
	localparam int PW  = 2 * OPW;
	localparam int AW  = 8;
	localparam int DW  = 32;

	// register byte addresses
	localparam logic [AW-1:0] REG_CTRL    = 8'h00;
	localparam logic [AW-1:0] REG_OPERAND = 8'h04;
	localparam logic [AW-1:0] REG_PRODUCT = 8'h08;
	localparam logic [AW-1:0] REG_STATUS  = 8'h0C;

	// control register fields
	localparam int CB_SCHEME = 0;
	localparam int CB_XSIGN  = 1;
	localparam int CB_YSIGN  = 2;
	localparam int CB_FA     = 3;
	localparam int CB_FT     = 4;
	localparam int CB_RND    = 5;
	localparam int CB_HSEL   = 6;
	localparam int CB_POE_N  = 7;
	localparam int CB_LOE_N  = 8;
	localparam int CTRL_W    = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h188;

	// status register fields
	localparam int SB_XSIGN = 0;
	localparam int SB_YSIGN = 1;
	localparam int SB_RND   = 2;
	localparam int SB_W     = 3;

	// round insertion point before the format shift
	localparam int RND_POS_FULL  = 15;
	localparam int RND_POS_SHIFT = 14;

	// synchroniser layout of the pin inputs
	localparam int SY_X    = 0;
	localparam int SY_Y    = OPW;
	localparam int SY_CKX  = 2 * OPW;
	localparam int SY_CKY  = SY_CKX + 1;
	localparam int SY_CKH  = SY_CKX + 2;
	localparam int SY_CKL  = SY_CKX + 3;
	localparam int SY_ENX  = SY_CKX + 4;
	localparam int SY_ENY  = SY_CKX + 5;
	localparam int SY_ENP  = SY_CKX + 6;
	localparam int SYNC_W  = SY_CKX + 7;

	typedef enum logic {
		RMUL_SEP_CLOCKS,
		RMUL_ONE_CLOCK
	} rmul_scheme_t;
endpackage

/* rtl/rmul_top.sv */
// registered 16x16 multiplier with APB control and pin-side loading
// Contract
// - x clock edge captures multiplicand, its sign mode and round request.
// - y clock edge captures multiplier operand, its sign mode and round request.
// - separate clocks: upper product clock edge loads upper product half.
// - separate clocks: lower product clock edge loads lower product half.
// - single clock: all registers load on the shared clock under their enables.
// - three enables: x group, y group, both product halves together.
// - each operand unsigned when its sign mode low, two's complement when high.
// - format adjust high gives the full 32-bit product unshifted.
// - format adjust low shifts left one, sign copied into lower half top bit.
// - transparency high makes both product registers follow the product.
// - y pins are operand input and three-state lower product output.
// - round adds one at lower half top bit, 14 or 15 per format.
// - round request registers on either operand clock edge.
// - product port shows upper half when select low, lower when high.
// - product port and y pins driven only under their active-low enables.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module rmul_top
	import rmul_pkg::*;
(
	// clock, reset, freeze
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            ce,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [AW-1:0]   paddr,
	input  wire logic [DW-1:0]   pwdata,
	output logic      [DW-1:0]   prdata,
	output logic                 pready,
	output logic                 pslverr,
	// operand pins
	input  wire logic [OPW-1:0]  x_data,
	input  wire logic [OPW-1:0]  y_in,
	output logic      [OPW-1:0]  y_out,
	output logic                 y_oe,
	// separate-clock loads
	input  wire logic            x_operand_clock,
	input  wire logic            y_operand_clock,
	input  wire logic            upper_product_clock,
	input  wire logic            lower_product_clock,
	// single-clock enables
	input  wire logic            x_load_enable,
	input  wire logic            y_load_enable,
	input  wire logic            product_load_enable,
	// product port
	output logic      [OPW-1:0]  product_out,
	output logic                 product_oe
);
	rmul_mul_if mul ();

	logic [CTRL_W-1:0] ctrl;
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [3:0]        clk_prev;
	logic [OPW-1:0]    x_reg;
	logic [OPW-1:0]    y_reg;
	logic              x_sign;
	logic              y_sign;
	logic              rnd_reg;
	logic [OPW-1:0]    upper_product_half;
	logic [OPW-1:0]    lower_product_half;

	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	// pin synchronisers: first stage feeds only the second
	wire [SYNC_W-1:0] pins = {product_load_enable, y_load_enable, x_load_enable,
		lower_product_clock, upper_product_clock, y_operand_clock, x_operand_clock,
		y_in, x_data};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1    <= '0;
			sync2    <= '0;
			clk_prev <= '0;
		end else if (ce) begin
			sync1    <= pins;
			sync2    <= sync1;
			clk_prev <= sync2[SY_CKL:SY_CKX];
		end
	end

	// decoded control fields
	wire one_clock     = ctrl[CB_SCHEME] == RMUL_ONE_CLOCK;
	wire format_adjust = ctrl[CB_FA];
	wire transparent   = ctrl[CB_FT];
	wire half_select   = ctrl[CB_HSEL];
	wire x_pin_edge    = rise(sync2[SY_CKX], clk_prev[0]);
	wire y_pin_edge    = rise(sync2[SY_CKY], clk_prev[1]);
	wire hi_pin_edge   = rise(sync2[SY_CKH], clk_prev[2]);
	wire lo_pin_edge   = rise(sync2[SY_CKL], clk_prev[3]);
	wire [OPW-1:0] x_s = sync2[SY_X +: OPW];
	wire [OPW-1:0] y_s = sync2[SY_Y +: OPW];

	wire ld_x  = ce & (one_clock ? sync2[SY_ENX] : x_pin_edge);
	wire ld_y  = ce & (one_clock ? sync2[SY_ENY] : y_pin_edge);
	wire ld_hi = ce & (transparent | (one_clock ? sync2[SY_ENP] : hi_pin_edge));
	wire ld_lo = ce & (transparent | (one_clock ? sync2[SY_ENP] : lo_pin_edge));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x_reg  <= '0;
			x_sign <= 1'b0;
		end else if (ld_x) begin
			x_reg  <= x_s;
			x_sign <= ctrl[CB_XSIGN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			y_reg  <= '0;
			y_sign <= 1'b0;
		end else if (ld_y) begin
			y_reg  <= y_s;
			y_sign <= ctrl[CB_YSIGN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rnd_reg <= 1'b0;
		end else if (ld_x | ld_y) begin
			rnd_reg <= ctrl[CB_RND];
		end
	end

	// array fed straight from operand registers
	assign mul.x   = x_reg;
	assign mul.y   = y_reg;
	assign mul.xs  = x_sign;
	assign mul.ys  = y_sign;
	assign mul.fa  = format_adjust;
	assign mul.rnd = rnd_reg;

	rmul_core u_core (
		.m (mul)
	);

	// host must hold operands until the product is clocked; no interlock here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_product_half <= '0;
		end else if (ld_hi) begin
			upper_product_half <= mul.hi;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_product_half <= '0;
		end else if (ld_lo) begin
			lower_product_half <= mul.lo;
		end
	end

	// output stage: costs one cycle but keeps every pin on a flop
	// half select
	wire [OPW-1:0] next_product_out = half_select ? lower_product_half : upper_product_half;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			product_out <= '0;
			product_oe  <= 1'b0;
			y_out       <= '0;
			y_oe        <= 1'b0;
		end else if (ce) begin
			product_out <= next_product_out;
			product_oe  <= ~ctrl[CB_POE_N];
			// lower half back out on y pins
			y_out       <= lower_product_half;
			y_oe        <= ~ctrl[CB_LOE_N];
		end
	end

	// apb: one wait state so read data can leave a flop
	wire access   = psel & penable & ~pready;
	wire fire     = psel & penable & pready & ce;
	wire hit_ctrl = paddr == REG_CTRL;
	wire hit_any  = hit_ctrl | (paddr == REG_OPERAND) | (paddr == REG_PRODUCT)
		| (paddr == REG_STATUS);
	wire [SB_W-1:0] status = {rnd_reg, y_sign, x_sign};
	wire [DW-1:0] rd_word =
		hit_ctrl                ? DW'(ctrl) :
		(paddr == REG_OPERAND)  ? {y_reg, x_reg} :
		(paddr == REG_PRODUCT)  ? {upper_product_half, lower_product_half} :
		(paddr == REG_STATUS)   ? DW'(status) : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= access;
			pslverr <= access & ~hit_any;
			prdata  <= (access & ~pwrite) ? rd_word : '0;
		end
	end

	// writes land only at the completing edge; other offsets are read-only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (fire & pwrite & hit_ctrl) begin
			ctrl <= pwdata[CTRL_W-1:0];
		end
	end

	// reference product for checking, assertion use only
	wire signed [OPW:0]  chk_x = {x_sign & x_reg[OPW-1], x_reg};
	wire signed [OPW:0]  chk_y = {y_sign & y_reg[OPW-1], y_reg};
	wire signed [PW+1:0] chk_p = (PW+2)'(chk_x) * (PW+2)'(chk_y);

	a_x_capture: assert property (@(posedge pclk) disable iff (!presetn)
		ld_x |=> x_reg == $past(x_s) && x_sign == $past(ctrl[CB_XSIGN]))
		else $error("x operand group not captured");

	a_y_capture: assert property (@(posedge pclk) disable iff (!presetn)
		ld_y |=> y_reg == $past(y_s) && y_sign == $past(ctrl[CB_YSIGN]))
		else $error("y operand group not captured");

	a_upper_pin_load: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !one_clock && hi_pin_edge |=> upper_product_half == $past(mul.hi))
		else $error("upper half missed its clock edge");

	a_lower_pin_load: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !one_clock && lo_pin_edge |=> lower_product_half == $past(mul.lo))
		else $error("lower half missed its clock edge");

	a_enable_hold: assert property (@(posedge pclk) disable iff (!presetn)
		ce && one_clock && !sync2[SY_ENX] && !sync2[SY_ENY] |=> $stable(x_reg) && $stable(y_reg))
		else $error("operand changed without enable");

	a_pair_enable: assert property (@(posedge pclk) disable iff (!presetn)
		ce && one_clock && sync2[SY_ENP]
		|=> upper_product_half == $past(mul.hi) && lower_product_half == $past(mul.lo))
		else $error("product pair not loaded together");

	a_full_format: assert property (@(posedge pclk) disable iff (!presetn)
		format_adjust && !rnd_reg |-> {mul.hi, mul.lo} == chk_p[PW-1:0])
		else $error("full product mismatch");

	a_shift_format: assert property (@(posedge pclk) disable iff (!presetn)
		!format_adjust && !rnd_reg
		|-> mul.hi == chk_p[PW-2:OPW-1] && mul.lo == {chk_p[PW-1], chk_p[OPW-2:0]})
		else $error("shifted product mismatch");

	a_transparent_follow: assert property (@(posedge pclk) disable iff (!presetn)
		ce && transparent |=> upper_product_half == $past(mul.hi)
		&& lower_product_half == $past(mul.lo))
		else $error("transparent halves did not follow");

	a_round_either: assert property (@(posedge pclk) disable iff (!presetn)
		(ld_x || ld_y) ##1 !(ld_x || ld_y) [*2] |-> rnd_reg == $past(ctrl[CB_RND], 2))
		else $error("round request not registered");

	a_half_select: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> product_out == $past(next_product_out))
		else $error("wrong product half on port");

	a_drive_enable: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> product_oe == !$past(ctrl[CB_POE_N]) && y_oe == !$past(ctrl[CB_LOE_N]))
		else $error("output enable mismatch");

	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		ce && psel && penable && !pready ##1 ce |-> pready)
		else $error("apb answer late");
endmodule
